// ==== core/ulin_pkg.sv ====
// Constants, register map and shared helpers of the LIN/IrDA serial port
package ulin_pkg;
  localparam int unsigned ULIN_CLK_HZ = 100_000_000;
  localparam int unsigned ULIN_BAUD_BPS = 19_200;
  localparam int unsigned ULIN_OVERSAMPLE = 16;
  localparam logic [15:0] ULIN_BAUD_RST =
    16'(ULIN_CLK_HZ / (ULIN_BAUD_BPS * ULIN_OVERSAMPLE));
  // Low-power infrared clock, typically 1.8432 MHz (1.42 to 2.12 MHz)
  localparam int unsigned ULIN_INFRARED_LOW_POWER_SELECT_KHZ = 1843;
  localparam logic [7:0] ULIN_PSC_RST =
    8'(ULIN_CLK_HZ / (ULIN_INFRARED_LOW_POWER_SELECT_KHZ * 1000));

  // Register byte offsets
  localparam logic [7:0] ULIN_OFS_STAT = 8'h00;
  localparam logic [7:0] ULIN_OFS_DATA = 8'h04;
  localparam logic [7:0] ULIN_OFS_BAUD = 8'h08;
  localparam logic [7:0] ULIN_OFS_CTRL = 8'h0c;
  localparam logic [7:0] ULIN_OFS_PSC = 8'h10;

  // Control register bit positions
  localparam int ULIN_C_TXEN = 0;
  localparam int ULIN_C_RXEN = 1;
  localparam int ULIN_C_LIN_MODE_ENABLE = 2;
  localparam int ULIN_C_SBK = 3;
  localparam int ULIN_C_BLEN = 4;
  localparam int ULIN_C_BIE = 5;
  localparam int ULIN_C_HIE = 6;
  localparam int ULIN_C_RIE = 7;
  localparam int ULIN_C_SLV = 8;
  localparam int ULIN_C_PARITY_CHECK_ENABLE = 9;
  localparam int ULIN_C_IREN = 10;
  localparam int ULIN_C_INFRARED_LOW_POWER_SELECT = 11;
  localparam int ULIN_CTRL_W = 12;
  localparam logic [11:0] ULIN_CTRL_RST = 12'h000;

  // Status register bit positions
  localparam int ULIN_S_RECEIVE_NOT_EMPTY_FLAG = 0;
  localparam int ULIN_S_TC = 1;
  localparam int ULIN_S_FE = 2;
  localparam int ULIN_S_PE = 3;
  localparam int ULIN_S_OVR = 4;
  localparam int ULIN_S_BRK = 5;
  localparam int ULIN_S_HDR = 6;
  localparam int ULIN_STAT_W = 7;
  localparam logic [6:0] ULIN_STAT_RST = 7'h02;

  // Bit timing
  localparam logic [3:0] ULIN_SAMP_A = 4'd7;
  localparam logic [3:0] ULIN_SAMP_B = 4'd8;
  localparam logic [3:0] ULIN_SAMP_C = 4'd9;
  localparam logic [3:0] ULIN_SAMP_LAST = 4'd15;
  localparam logic [3:0] ULIN_BRK_TX_BITS = 4'd13;
  localparam logic [3:0] ULIN_BRK_SHORT = 4'd10;
  localparam logic [3:0] ULIN_BRK_LONG = 4'd11;
  localparam logic [3:0] ULIN_IR_PULSE = 4'd3;
  localparam logic [1:0] ULIN_IR_GLITCH = 2'd2;
  localparam logic [3:0] ULIN_IR_HOLD = 4'd8;
  localparam logic [1:0] ULIN_HDR_ID = 2'd2;

  function automatic logic ulin_vote(input logic a, input logic b,
                                     input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // True when both identifier parity bits match the LIN definition
  function automatic logic ulin_id_ok(input logic [7:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return (id[6] == p0) && (id[7] == p1);
  endfunction
endpackage

// ==== core/ulin_brkdet.sv ====
// Break and delimiter detector, independent of the data receiver
module ulin_brkdet import ulin_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic rxd,
  input wire logic tick16,
  input wire logic long_sel,
  output logic brk_det,
  output logic brk_abort
);
  typedef enum logic [1:0] {BD_HUNT, BD_COUNT, BD_DELIM} ulin_bd_t;
  ulin_bd_t st_ff;
  logic [3:0] samp_ff;
  logic [3:0] zeros_ff;
  logic sa_ff;
  logic sb_ff;
  logic vote;
  logic [3:0] need;

  assign vote = ulin_vote(sa_ff, sb_ff, rxd);
  assign need = long_sel ? ULIN_BRK_LONG : ULIN_BRK_SHORT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= BD_HUNT;
      samp_ff <= 4'h0;
      zeros_ff <= 4'h0;
      sa_ff <= 1'b1;
      sb_ff <= 1'b1;
      brk_det <= 1'b0;
      brk_abort <= 1'b0;
    end else begin
      brk_det <= 1'b0;
      brk_abort <= 1'b0;
      if (!enable) begin
        st_ff <= BD_HUNT;
      end else if (tick16) begin
        samp_ff <= samp_ff + 4'h1;
        if (samp_ff == ULIN_SAMP_A) sa_ff <= rxd;
        if (samp_ff == ULIN_SAMP_B) sb_ff <= rxd;
        unique case (st_ff)
          BD_HUNT: begin
            if (!rxd) begin
              st_ff <= BD_COUNT;
              samp_ff <= 4'h1;
              zeros_ff <= 4'h0;
            end
          end
          BD_COUNT: begin
            if (samp_ff == ULIN_SAMP_C) begin
              if (vote) begin
                st_ff <= BD_HUNT;
                brk_abort <= 1'b1;
              end else if (zeros_ff + 4'h1 == need) begin
                st_ff <= BD_DELIM;
              end else begin
                zeros_ff <= zeros_ff + 4'h1;
              end
            end
          end
          BD_DELIM: begin
            if (samp_ff == ULIN_SAMP_C && vote) begin
              st_ff <= BD_HUNT;
              brk_det <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule

// ==== core/ulin_top.sv ====
// Serial port with LIN master/slave support and IrDA low-power coding
// Overview of operation
// - Low-power IrDA zero pulse is three clocks
// - Prescaler divides system clock to infrared clock
// - Low-power infrared glitch filter needs two prescaler periods
// - Break request sends 13 zeros, one delimiter
// - Break flag only from received break
// - Break detector runs apart, whenever receiver and LIN mode are enabled
// - Detector samples 8th, 9th, 10th like receiver
// - 10 or 11 zeros plus delimiter set flag when not slave
// - A one aborts break detection
// - LIN off: receiver ignores break detection
// - LIN framing error halts receiver until resolved
// - Response bytes 8N1, sent and received as plain data
// - Break sets data and framing flags first
// - Slave sets header flag, identifier readable
// - Parity error flagged with header flag
// - Parity uses identifier top two bits
module ulin_top import ulin_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic rx_pin,
  input wire logic ir_rx_pin,
  output logic tx_ff,
  output logic ir_tx_ff,
  output logic irq_ff
);
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BRK, TX_DELIM
  } ulin_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HALT
  } ulin_rx_t;

  logic [ULIN_CTRL_W-1:0] ctrl_ff;
  logic [ULIN_STAT_W-1:0] stat_ff;
  logic [15:0] baud_ff;
  logic [7:0] psc_ff;
  logic [7:0] rdata_ff;
  logic [7:0] thr_ff;
  logic thr_full_ff;
  logic [1:0] rx_sync_ff;
  logic [1:0] ir_sync_ff;
  logic [15:0] baud_cnt_ff;
  logic tick16_ff;
  logic [7:0] psc_cnt_ff;
  logic lp_tick_ff;
  ulin_tx_t tx_st_ff;
  logic [3:0] tx_ph_ff;
  logic [3:0] tx_bits_ff;
  logic [7:0] tx_sh_ff;
  logic [3:0] ir_lp_left_ff;
  logic [1:0] ir_low_ff;
  logic [3:0] ir_hold_ff;
  ulin_rx_t rx_st_ff;
  logic [3:0] rx_samp_ff;
  logic [2:0] rx_bits_ff;
  logic [7:0] rx_sh_ff;
  logic rx_sa_ff;
  logic rx_sb_ff;
  logic [1:0] hdr_cnt_ff;
  logic brk_det;
  logic brk_abort;

  logic lin_en;
  logic rxd;
  logic rx_vote;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic data_wr;
  logic data_rd;
  logic tx_bit;
  logic tx_bit_end;
  logic byte_ok;
  logic byte_fe;
  logic hdr_hit;
  logic [31:0] rd_mux;
  logic mapped;
  logic ir_lp_start;

  assign lin_en = ctrl_ff[ULIN_C_LIN_MODE_ENABLE];
  assign acc_done = psel & penable & pready_ff;
  assign wr_done = acc_done & pwrite & mapped;
  assign rd_done = acc_done & ~pwrite & mapped;
  assign data_wr = wr_done & (paddr == ULIN_OFS_DATA);
  assign data_rd = rd_done & (paddr == ULIN_OFS_DATA);
  assign mapped = (paddr == ULIN_OFS_STAT) | (paddr == ULIN_OFS_DATA) |
                  (paddr == ULIN_OFS_BAUD) | (paddr == ULIN_OFS_CTRL) |
                  (paddr == ULIN_OFS_PSC);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ULIN_OFS_STAT: rd_mux = {25'h0, stat_ff};
      ULIN_OFS_DATA: rd_mux = {24'h0, rdata_ff};
      ULIN_OFS_BAUD: rd_mux = {16'h0, baud_ff};
      ULIN_OFS_CTRL: rd_mux = {20'h0, ctrl_ff};
      ULIN_OFS_PSC: rd_mux = {24'h0, psc_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
      if (psel & penable & ~pready_ff) prdata_ff <= mapped ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= ULIN_CTRL_RST;
      baud_ff <= ULIN_BAUD_RST;
      psc_ff <= ULIN_PSC_RST;
    end else begin
      if (wr_done && paddr == ULIN_OFS_CTRL)
        ctrl_ff <= pwdata[ULIN_CTRL_W-1:0];
      else if (tx_st_ff == TX_DELIM && tx_bit_end)
        ctrl_ff[ULIN_C_SBK] <= 1'b0;
      if (wr_done && paddr == ULIN_OFS_BAUD) baud_ff <= pwdata[15:0];
      if (wr_done && paddr == ULIN_OFS_PSC) psc_ff <= pwdata[7:0];
    end
  end

  // Pins cross into the clock domain through two flops each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync_ff <= 2'b11;
      ir_sync_ff <= 2'b11;
    end else begin
      rx_sync_ff <= {rx_sync_ff[0], rx_pin};
      ir_sync_ff <= {ir_sync_ff[0], ir_rx_pin};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_ff <= 16'h0000;
      tick16_ff <= 1'b0;
      psc_cnt_ff <= 8'h00;
      lp_tick_ff <= 1'b0;
    end else begin
      tick16_ff <= 1'b0;
      lp_tick_ff <= 1'b0;
      if (baud_cnt_ff + 16'h1 >= baud_ff) begin
        baud_cnt_ff <= 16'h0000;
        tick16_ff <= 1'b1;
      end else begin
        baud_cnt_ff <= baud_cnt_ff + 16'h1;
      end
      // A zero prescaler gives no infrared clock at all
      if (psc_ff == 8'h00) begin
        psc_cnt_ff <= 8'h00;
      end else if (psc_cnt_ff + 8'h1 >= psc_ff) begin
        psc_cnt_ff <= 8'h00;
        lp_tick_ff <= 1'b1;
      end else begin
        psc_cnt_ff <= psc_cnt_ff + 8'h1;
      end
      // Restart the infrared clock so a pulse spans three whole periods
      if (ir_lp_start) begin
        psc_cnt_ff <= 8'h01;
        lp_tick_ff <= 1'b0;
      end
    end
  end

  // Transmitter
  always_comb begin
    unique case (tx_st_ff)
      TX_START, TX_BRK: tx_bit = 1'b0;
      TX_DATA: tx_bit = tx_sh_ff[0];
      default: tx_bit = 1'b1;
    endcase
  end
  assign tx_bit_end = tick16_ff & (tx_ph_ff == ULIN_SAMP_LAST);
  assign ir_lp_start = ctrl_ff[ULIN_C_IREN] & ctrl_ff[ULIN_C_INFRARED_LOW_POWER_SELECT] &
                       tick16_ff & (tx_ph_ff == 4'h0) & ~tx_bit &
                       (tx_st_ff != TX_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff <= TX_IDLE;
      tx_ph_ff <= 4'h0;
      tx_bits_ff <= 4'h0;
      tx_sh_ff <= 8'h00;
      thr_ff <= 8'h00;
      thr_full_ff <= 1'b0;
    end else begin
      if (data_wr) begin
        thr_ff <= pwdata[7:0];
        thr_full_ff <= 1'b1;
      end
      if (tick16_ff) tx_ph_ff <= tx_ph_ff + 4'h1;
      unique case (tx_st_ff)
        TX_IDLE: begin
          tx_ph_ff <= 4'h0;
          tx_bits_ff <= 4'h0;
          // A pending break goes out ahead of queued data
          if (ctrl_ff[ULIN_C_TXEN] && ctrl_ff[ULIN_C_SBK] && lin_en) begin
            tx_st_ff <= TX_BRK;
          end else if (ctrl_ff[ULIN_C_TXEN] && thr_full_ff && !data_wr) begin
            tx_st_ff <= TX_START;
            tx_sh_ff <= thr_ff;
            thr_full_ff <= 1'b0;
          end
        end
        TX_START: if (tx_bit_end) tx_st_ff <= TX_DATA;
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            tx_bits_ff <= tx_bits_ff + 4'h1;
            if (tx_bits_ff == 4'd7) tx_st_ff <= TX_STOP;
          end
        end
        TX_STOP: if (tx_bit_end) tx_st_ff <= TX_IDLE;
        TX_BRK: begin
          if (tx_bit_end) begin
            tx_bits_ff <= tx_bits_ff + 4'h1;
            if (tx_bits_ff + 4'h1 == ULIN_BRK_TX_BITS)
              tx_st_ff <= TX_DELIM;
          end
        end
        TX_DELIM: if (tx_bit_end) tx_st_ff <= TX_IDLE;
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // Infrared encoder: a zero bit becomes a short high pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ff <= 1'b1;
      ir_tx_ff <= 1'b0;
      ir_lp_left_ff <= 4'h0;
    end else begin
      tx_ff <= tx_bit;
      if (tick16_ff && tx_ph_ff == 4'h0 && !tx_bit)
        ir_lp_left_ff <= ULIN_IR_PULSE;
      else if (lp_tick_ff && ir_lp_left_ff != 4'h0)
        ir_lp_left_ff <= ir_lp_left_ff - 4'h1;
      if (!ctrl_ff[ULIN_C_IREN] || tx_st_ff == TX_IDLE)
        ir_tx_ff <= 1'b0;
      else if (ctrl_ff[ULIN_C_INFRARED_LOW_POWER_SELECT])
        ir_tx_ff <= ir_lp_left_ff != 4'h0;
      else
        ir_tx_ff <= !tx_bit && tx_ph_ff < ULIN_IR_PULSE;
    end
  end

  // Infrared decoder; reception is ignored while transmitting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_low_ff <= 2'b00;
      ir_hold_ff <= 4'h0;
    end else begin
      if (ir_sync_ff[1] || tx_st_ff != TX_IDLE)
        ir_low_ff <= 2'b00;
      else if (lp_tick_ff && ir_low_ff != ULIN_IR_GLITCH)
        ir_low_ff <= ir_low_ff + 2'b01;
      // In low-power mode short lows never reach the counter limit and are dropped
      if ((ctrl_ff[ULIN_C_INFRARED_LOW_POWER_SELECT] && lp_tick_ff &&
           ir_low_ff + 2'b01 == ULIN_IR_GLITCH) ||
          (!ctrl_ff[ULIN_C_INFRARED_LOW_POWER_SELECT] && !ir_sync_ff[1] && tx_st_ff == TX_IDLE))
        ir_hold_ff <= ULIN_IR_HOLD;
      else if (tick16_ff && ir_hold_ff != 4'h0)
        ir_hold_ff <= ir_hold_ff - 4'h1;
    end
  end

  assign rxd = ctrl_ff[ULIN_C_IREN] ? (ir_hold_ff == 4'h0) : rx_sync_ff[1];
  assign rx_vote = ulin_vote(rx_sa_ff, rx_sb_ff, rxd);

  ulin_brkdet u_brkdet (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl_ff[ULIN_C_RXEN] & lin_en),
    .rxd(rxd),
    .tick16(tick16_ff),
    .long_sel(ctrl_ff[ULIN_C_BLEN]),
    .brk_det(brk_det),
    .brk_abort(brk_abort)
  );

  // Data receiver with 8th/9th/10th sample vote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff <= RX_IDLE;
      rx_samp_ff <= 4'h0;
      rx_bits_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_sa_ff <= 1'b1;
      rx_sb_ff <= 1'b1;
    end else if (!ctrl_ff[ULIN_C_RXEN]) begin
      rx_st_ff <= RX_IDLE;
    end else if (rx_st_ff == RX_HALT) begin
      if (brk_abort || brk_det || !lin_en) rx_st_ff <= RX_IDLE;
    end else if (tick16_ff) begin
      rx_samp_ff <= rx_samp_ff + 4'h1;
      if (rx_samp_ff == ULIN_SAMP_A) rx_sa_ff <= rxd;
      if (rx_samp_ff == ULIN_SAMP_B) rx_sb_ff <= rxd;
      unique case (rx_st_ff)
        RX_IDLE: begin
          if (!rxd) begin
            rx_st_ff <= RX_START;
            rx_samp_ff <= 4'h1;
          end
        end
        RX_START: begin
          if (rx_samp_ff == ULIN_SAMP_C && rx_vote) rx_st_ff <= RX_IDLE;
          if (rx_samp_ff == ULIN_SAMP_LAST) begin
            rx_st_ff <= RX_DATA;
            rx_bits_ff <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_samp_ff == ULIN_SAMP_C) begin
            rx_sh_ff <= {rx_vote, rx_sh_ff[7:1]};
            rx_bits_ff <= rx_bits_ff + 3'h1;
            if (rx_bits_ff == 3'h7) rx_st_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_samp_ff == ULIN_SAMP_C)
            rx_st_ff <= (!rx_vote && lin_en) ? RX_HALT : RX_IDLE;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  assign byte_ok = tick16_ff & (rx_st_ff == RX_STOP) &
                   (rx_samp_ff == ULIN_SAMP_C) & rx_vote;
  assign byte_fe = tick16_ff & (rx_st_ff == RX_STOP) &
                   (rx_samp_ff == ULIN_SAMP_C) & ~rx_vote;
  assign hdr_hit = byte_ok & lin_en & ctrl_ff[ULIN_C_SLV] &
                   (hdr_cnt_ff == ULIN_HDR_ID - 2'b01);

  // Slave header tracking: count good bytes after a break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_cnt_ff <= ULIN_HDR_ID;
    end else if (brk_det) begin
      hdr_cnt_ff <= 2'b00;
    end else if (byte_fe) begin
      hdr_cnt_ff <= ULIN_HDR_ID;
    end else if (byte_ok && hdr_cnt_ff != ULIN_HDR_ID) begin
      hdr_cnt_ff <= hdr_cnt_ff + 2'b01;
    end
  end

  // Status flags: hardware set wins over a software write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= ULIN_STAT_RST;
      rdata_ff <= 8'h00;
    end else begin
      if (wr_done && paddr == ULIN_OFS_STAT)
        stat_ff <= stat_ff & ~pwdata[ULIN_STAT_W-1:0];
      if (data_rd) stat_ff[ULIN_S_RECEIVE_NOT_EMPTY_FLAG] <= 1'b0;
      if (data_wr) stat_ff[ULIN_S_TC] <= 1'b0;
      if (tx_st_ff != TX_IDLE && tx_bit_end &&
          (tx_st_ff == TX_STOP || tx_st_ff == TX_DELIM) && !thr_full_ff)
        stat_ff[ULIN_S_TC] <= 1'b1;
      if (byte_ok || byte_fe) begin
        rdata_ff <= rx_sh_ff;
        stat_ff[ULIN_S_RECEIVE_NOT_EMPTY_FLAG] <= 1'b1;
        if (stat_ff[ULIN_S_RECEIVE_NOT_EMPTY_FLAG] && !data_rd) stat_ff[ULIN_S_OVR] <= 1'b1;
      end
      if (byte_fe) stat_ff[ULIN_S_FE] <= 1'b1;
      if (brk_det && !ctrl_ff[ULIN_C_SLV])
        stat_ff[ULIN_S_BRK] <= 1'b1;
      if (hdr_hit) begin
        stat_ff[ULIN_S_HDR] <= 1'b1;
        if (ctrl_ff[ULIN_C_PARITY_CHECK_ENABLE] && !ulin_id_ok(rx_sh_ff))
          stat_ff[ULIN_S_PE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (stat_ff[ULIN_S_BRK] & ctrl_ff[ULIN_C_BIE]) |
                (stat_ff[ULIN_S_HDR] & ctrl_ff[ULIN_C_HIE]) |
                (stat_ff[ULIN_S_RECEIVE_NOT_EMPTY_FLAG] & ctrl_ff[ULIN_C_RIE]);
    end
  end
endmodule

// ==== sim/ulin_monitor.sv ====
// Port-level checks for the LIN/IrDA serial port
module ulin_monitor import ulin_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic rx_pin,
  input wire logic ir_rx_pin,
  input wire logic tx_ff,
  input wire logic ir_tx_ff,
  input wire logic irq_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ok;
  logic bad_adr;
  logic [11:0] ctrl_ff;
  logic [15:0] baud_ff;
  logic [7:0] psc_ff;
  logic [31:0] lo_ff;
  logic [31:0] hi_ff;
  assign wr_ok = psel & penable & pready_ff & pwrite;
  assign bad_adr = (paddr > 8'h10) || (paddr[1:0] != 2'h0);
  // Shadow settings, so pulse lengths are judged on what software chose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 12'h000;
      baud_ff <= 16'h0145;
      psc_ff <= 8'h36;
    end else if (wr_ok) begin
      if (paddr == ULIN_OFS_CTRL) ctrl_ff <= pwdata[11:0];
      if (paddr == ULIN_OFS_BAUD) baud_ff <= pwdata[15:0];
      if (paddr == ULIN_OFS_PSC) psc_ff <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_ff <= 32'h0;
      hi_ff <= 32'h0;
    end else begin
      lo_ff <= tx_ff ? 32'h0 : lo_ff + 32'h1;
      hi_ff <= ir_tx_ff ? hi_ff + 32'h1 : 32'h0;
    end
  end
  a_ready_one_wait: assert property (psel && !penable ##1 psel && penable
    |-> !pready_ff ##1 pready_ff) else $error("ready not after one wait");
  a_ready_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  a_err_map: assert property (pready_ff |-> pslverr_ff == bad_adr)
    else $error("error response does not match address");
  a_err_read_zero: assert property (pready_ff && !pwrite && bad_adr
    |-> prdata_ff == 32'h0) else $error("unmapped read not zero");
  a_reset_idle: assert property ($rose(presetn)
    |-> tx_ff && !ir_tx_ff && !irq_ff && !pready_ff)
    else $error("outputs not idle after reset");
  a_irq_needs_en: assert property (
    irq_ff |-> $past(ctrl_ff[7:5]) != 3'h0)
    else $error("interrupt without enable");
  a_tx_run_len: assert property (
    $rose(tx_ff) |-> lo_ff <= 32'(9 * 16) * baud_ff
    || lo_ff == 32'(13 * 16) * baud_ff)
    else $error("low run on transmit has illegal length");
  a_ir_pulse_len: assert property (
    $fell(ir_tx_ff) |-> hi_ff == 32'(ULIN_IR_PULSE) *
    (ctrl_ff[ULIN_C_INFRARED_LOW_POWER_SELECT] ? 32'(psc_ff) : 32'(baud_ff)))
    else $error("infrared pulse has wrong width");
  c_break: cover property ($rose(tx_ff) && lo_ff > 32'(9 * 16) * baud_ff);
  c_slverr: cover property (pready_ff && pslverr_ff);
  c_ir_lp: cover property ($fell(ir_tx_ff) && ctrl_ff[ULIN_C_INFRARED_LOW_POWER_SELECT]);
endmodule

// ==== sim/ulin_lin_node.sv ====
// Behavioural LIN node sharing the wire with the port's transmitter
module ulin_lin_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk,
  input wire logic dut_tx,
  output logic bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  // Wired-AND with pull-up: a released node leaves the bus recessive
  assign bus = dut_tx & drv;
  initial drv = 1'b1;
  // Dominant run of n bits, then delimiter and idle
  task automatic send_low(input int n);
    @(posedge pclk);
    drv <= 1'b0;
    repeat (n * BIT_CYC) @(posedge pclk);
    drv <= 1'b1;
    repeat (3 * BIT_CYC) @(posedge pclk);
  endtask
  // 8N1 frame, least significant bit first
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      drv <= f[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask
endmodule

// ==== sim/ulin_tb_top.sv ====
// Self-checking testbench of the LIN/IrDA serial port
module ulin_tb_top import ulin_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff;
  logic rx_pin, ir_rx_pin, tx_ff, ir_tx_ff, irq_ff;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_ff, rdat;
  logic rerr;
  int num_errors, total_checks;
  ulin_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .rx_pin(rx_pin), .ir_rx_pin(ir_rx_pin),
    .tx_ff(tx_ff), .ir_tx_ff(ir_tx_ff), .irq_ff(irq_ff));
  ulin_lin_node u_node (.pclk(pclk), .dut_tx(tx_ff), .bus(rx_pin));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail_out();
    num_errors++;
    $display("[ERR] %0t timeout", $time);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1) begin
      if (n++ == 20) fail_out();
      @(posedge pclk);
    end
    rdat = prdata_ff;
    rerr = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads status until the bit is set; frames take a few hundred cycles
  task automatic poll(input int idx);
    int n;
    n = 0;
    rdat = 32'h0;
    while (rdat[idx] !== 1'b1) begin
      if (n++ == 300) fail_out();
      apb(1'b0, ULIN_OFS_STAT, 32'h0);
    end
  endtask
  function automatic logic lvl(input logic s);
    return s ? ir_tx_ff : ~tx_ff;
  endfunction
  task automatic measure(input logic s, output int n);
    int t;
    t = 0;
    n = 0;
    @(negedge pclk);
    while (lvl(s) !== 1'b1) begin
      if (t++ == 2000) fail_out();
      @(negedge pclk);
    end
    while (lvl(s) === 1'b1 && n < 5000) begin
      n++;
      @(negedge pclk);
    end
  endtask
  function automatic logic [7:0] lin_pid(input logic [5:0] i);
    logic p0;
    logic p1;
    p0 = i[0] ^ i[1] ^ i[2] ^ i[4];
    p1 = ~(i[1] ^ i[3] ^ i[4] ^ i[5]);
    return {p1, p0, i};
  endfunction
  function automatic logic [31:0] bt(input int p);
    return 32'h1 << p;
  endfunction
  initial begin
    logic [31:0] en;
    logic [7:0] b;
    int n;
    num_errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ir_rx_pin = 1'b1; // Infrared input idles high, so nothing is received on it
    void'($urandom(32'h089e));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ULIN_OFS_STAT, 0); chk(rdat, 32'h2);
    apb(1'b0, ULIN_OFS_BAUD, 0); chk(rdat, 32'h145);
    apb(1'b0, ULIN_OFS_CTRL, 0); chk(rdat, 32'h0);
    apb(1'b0, ULIN_OFS_PSC, 0); chk(rdat, 32'h36);
    apb(1'b0, 8'h14, 0); chk({rdat[30:0], rerr}, 32'h1);
    apb(1'b1, ULIN_OFS_BAUD, 32'h1);
    apb(1'b1, ULIN_OFS_CTRL, bt(ULIN_C_LIN_MODE_ENABLE));
    en = bt(ULIN_C_LIN_MODE_ENABLE) | bt(ULIN_C_TXEN) | bt(ULIN_C_RXEN);
    apb(1'b1, ULIN_OFS_CTRL, en | bt(ULIN_C_BIE));
    apb(1'b1, ULIN_OFS_STAT, 32'h7f);
    apb(1'b1, ULIN_OFS_CTRL, en | bt(ULIN_C_BIE) | bt(ULIN_C_SBK));
    measure(1'b0, n); chk(n, 13 * 16);
    poll(ULIN_S_BRK); chk(rdat[6:0], 7'h25);
    chk(irq_ff, 1'b1);
    apb(1'b1, ULIN_OFS_STAT, 32'h7f);
    repeat (2) @(negedge pclk);
    chk(irq_ff, 1'b0);
    for (int i = 0; i < 5; i++) begin
      b = (i == 0) ? 8'h55 : 8'($urandom);
      apb(1'b1, ULIN_OFS_DATA, b);
      poll(ULIN_S_RECEIVE_NOT_EMPTY_FLAG);
      apb(1'b0, ULIN_OFS_DATA, 0); chk(rdat, b);
    end
    apb(1'b1, ULIN_OFS_STAT, 32'h7f);
    apb(1'b1, ULIN_OFS_CTRL, en | bt(ULIN_C_SBK));
    apb(1'b1, ULIN_OFS_DATA, 32'h55);
    poll(ULIN_S_TC); chk(rdat[ULIN_S_BRK], 1'b1);
    apb(1'b1, ULIN_OFS_DATA, lin_pid(6'h2a));
    poll(ULIN_S_TC); chk(rdat[ULIN_S_RECEIVE_NOT_EMPTY_FLAG], 1'b1);
    for (int i = 0; i < 4; i++) begin
      n = (i + 19) / 2;
      apb(1'b1, ULIN_OFS_CTRL, en | (i[0] ? bt(ULIN_C_BLEN) : 0));
      apb(1'b1, ULIN_OFS_STAT, 32'h7f);
      u_node.send_low(n);
      apb(1'b0, ULIN_OFS_STAT, 0);
      chk(rdat[ULIN_S_BRK], n >= 10 + i[0]);
    end
    apb(1'b1, ULIN_OFS_CTRL, bt(ULIN_C_TXEN) | bt(ULIN_C_RXEN));
    apb(1'b1, ULIN_OFS_STAT, 32'h7f);
    u_node.send_low(13);
    apb(1'b0, ULIN_OFS_STAT, 0);
    chk({rdat[ULIN_S_BRK], rdat[ULIN_S_FE]}, 2'b01);
    en = bt(ULIN_C_TXEN) | bt(ULIN_C_RXEN) | bt(ULIN_C_SLV);
    apb(1'b1, ULIN_OFS_CTRL, en | bt(ULIN_C_PARITY_CHECK_ENABLE));
    en = en | bt(ULIN_C_PARITY_CHECK_ENABLE) | bt(ULIN_C_LIN_MODE_ENABLE);
    apb(1'b1, ULIN_OFS_CTRL, en);
    for (int k = 0; k < 2; k++) begin
      b = lin_pid(6'($urandom)) ^ (k[0] ? 8'h80 : 8'h00);
      apb(1'b1, ULIN_OFS_STAT, 32'h7f);
      u_node.send_low(13);
      u_node.send_byte(8'h55);
      u_node.send_byte(b);
      apb(1'b0, ULIN_OFS_STAT, 0);
      chk(rdat[6:5], 2'b10);
      chk(rdat[ULIN_S_PE], k[0]);
      apb(1'b0, ULIN_OFS_DATA, 0); chk(rdat, b);
    end
    apb(1'b1, ULIN_OFS_PSC, 32'h4);
    for (int k = 0; k < 2; k++) begin
      en = bt(ULIN_C_TXEN) | bt(ULIN_C_IREN);
      apb(1'b1, ULIN_OFS_CTRL, en | (k == 0 ? bt(ULIN_C_INFRARED_LOW_POWER_SELECT) : 0));
      apb(1'b1, ULIN_OFS_DATA, 32'h0);
      measure(1'b1, n); chk(n, k == 0 ? 12 : 3);
      poll(ULIN_S_TC);
    end
    wrap_up();
  end
endmodule
bind ulin_top ulin_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .rx_pin(rx_pin), .ir_rx_pin(ir_rx_pin),
  .tx_ff(tx_ff), .ir_tx_ff(ir_tx_ff), .irq_ff(irq_ff));
